// file: src/cfg_guard.sv
// Coordination flag write guard: allows or blocks received job data into host memory.
// Assumes one 25 MHz clock, synchronous inputs, and a host that refreshes the flag copy.
`timescale 1ns/100ps
`default_nettype none
`include "cfg_map.svh"

module cfg_guard #(
	parameter int FLAG_BYTES = `CFG_FLAG_BYTES,
	parameter int BYTE_AW = `CFG_BYTE_AW
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [FLAG_BYTES-1:0] flag_enable_switch,
	input wire logic copy_wr,
	input wire logic [BYTE_AW-1:0] copy_addr,
	input wire logic [7:0] copy_data,
	input wire logic cycle_end,
	input wire logic job_valid,
	input wire cfg_pkg::cfg_job_t job_in,
	output logic job_ready,
	output logic dest_write_en,
	output logic verdict_valid,
	output cfg_pkg::cfg_verdict_t verdict,
	output logic [15:0] receive_status_word,
	output logic [FLAG_BYTES-1:0] copy_fresh
);
	import cfg_pkg::*;

	cfg_state_t state_q;
	cfg_job_t job_q;
	logic [7:0] flag_byte;
	logic in_range;
	logic locked;
	logic [BYTE_AW-1:0] rd_addr;

	if (FLAG_BYTES != (1 << BYTE_AW) || BYTE_AW > 7)
	begin : g_bad_size
		$error("Flag byte count must equal two to the address width, at most 128.");
	end

	function automatic logic byte_usable(input logic [7:0] b, input logic [FLAG_BYTES-1:0] en);
		byte_usable = (b < 8'(FLAG_BYTES)) && en[b[BYTE_AW-1:0]];
	endfunction

	// Idle reads at the offered job's byte, so the test cycle sees the current copy.
	assign rd_addr = (state_q == CFG_IDLE) ? job_in.coord_byte[BYTE_AW-1:0]
		: job_q.coord_byte[BYTE_AW-1:0];

	// The copy holds plain host flag bytes, written only by the host refresh path.
	cfg_flag_ram #(.DEPTH(FLAG_BYTES), .AW(BYTE_AW)) u_copy (
		.clk(clk),
		.ce(ce),
		.wr_en(copy_wr),
		.wr_addr(copy_addr),
		.wr_data(copy_data),
		.rd_addr(rd_addr),
		.rd_data(flag_byte)
	);

	// Marks which bytes were refreshed in the current host cycle.
	always_ff @(posedge clk)
	begin
		if (reset)
			copy_fresh <= '0;
		else if (ce)
		begin
			// A write in the cycle of the host cycle end is kept: the set wins.
			if (cycle_end)
				copy_fresh <= '0;
			if (copy_wr)
				copy_fresh[copy_addr] <= 1'b1;
		end
	end

	assign in_range = byte_usable(job_q.coord_byte, flag_enable_switch);
	assign locked = job_q.coord_used && in_range && flag_byte[job_q.coord_bit];

	assign job_ready = (state_q == CFG_IDLE);

	// One job at a time; the decision waits one cycle for the registered flag read.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_q <= CFG_IDLE;
			job_q <= '0;
		end
		else if (ce)
		begin
			case (state_q)
				CFG_IDLE:
				begin
					if (job_valid)
					begin
						job_q <= job_in;
						state_q <= CFG_CHECK;
					end
				end
				CFG_CHECK:
					state_q <= locked ? CFG_BLOCK : CFG_PASS;
				CFG_PASS:
					state_q <= CFG_IDLE;
				CFG_BLOCK:
					state_q <= CFG_IDLE;
				default:
					state_q <= CFG_IDLE;
			endcase
		end
	end

	// Write enable is raised only after the decision, so a block never writes.
	always_ff @(posedge clk)
	begin
		if (reset)
			dest_write_en <= 1'b0;
		else if (ce)
			dest_write_en <= (state_q == CFG_CHECK) && !locked;
	end

	// Codes on acceptance are zero, so the requester reads success from the job status.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			verdict_valid <= 1'b0;
			verdict <= '0;
		end
		else if (ce)
		begin
			verdict_valid <= (state_q == CFG_CHECK);
			if (state_q == CFG_CHECK)
			begin
				if (locked)
				begin
					verdict.reply_code <= `CFG_REPLY_LOCKED;
					verdict.job_status <= `CFG_JOB_STATUS_LOCKED;
					verdict.system_status_area <= `CFG_SYS_AREA_LOCKED;
				end
				else
				begin
					verdict.reply_code <= `CFG_REPLY_OK;
					verdict.job_status <= `CFG_JOB_STATUS_OK;
					verdict.system_status_area <= 8'h00;
				end
			end
		end
	end

	// High byte carries the error number; low byte the job's flag byte number.
	always_ff @(posedge clk)
	begin
		if (reset)
			receive_status_word <= 16'h0000;
		else if (ce && state_q == CFG_CHECK)
		begin
			receive_status_word[7:0] <= job_q.coord_used ? job_q.coord_byte : 8'h00;
			receive_status_word[15:8] <= locked ? `CFG_STATUS_LOCKED : 8'h00;
		end
	end

	// Assertions skip reset; properties that count cycles count every clock edge, clock enable gaps included.
	sequence check_s;
		state_q == CFG_CHECK && ce;
	endsequence

	sequence take_s;
		ce && job_valid && job_ready;
	endsequence

	no_write_locked_a: assert property (@(posedge clk) disable iff (reset)
		check_s and locked |=> !dest_write_en && verdict.reply_code == 8'h32)
		else $error("Locked job wrote or replied wrongly.");
	status_locked_a: assert property (@(posedge clk) disable iff (reset)
		check_s and locked |=> verdict.job_status == 16'h0928 && verdict_valid)
		else $error("Requester status not 0928 on rejection.");
	pass_writes_a: assert property (@(posedge clk) disable iff (reset)
		check_s and !locked |=> dest_write_en)
		else $error("Unlocked job not written.");
	pass_codes_a: assert property (@(posedge clk) disable iff (reset)
		check_s and !locked |=> verdict == '0 && receive_status_word[15:8] == 8'h00)
		else $error("Accepted job reported an error code.");
	byte_report_a: assert property (@(posedge clk) disable iff (reset)
		check_s and job_q.coord_used |=> receive_status_word[7:0] == $past(job_q.coord_byte))
		else $error("Flag byte number missing from status word.");
	take_check_a: assert property (@(posedge clk) disable iff (reset)
		take_s |=> state_q == CFG_CHECK && job_q == $past(job_in))
		else $error("Taken job did not move to the flag test.");
	write_after_check_a: assert property (@(posedge clk) disable iff (reset)
		dest_write_en && $past(ce) |-> $past(state_q) == CFG_CHECK)
		else $error("Write without a preceding check.");
	block_hold_a: assert property (@(posedge clk) disable iff (reset)
		check_s and locked |=> (!dest_write_en) [*2])
		else $error("Rejected job reached the destination.");
	write_pulse_a: assert property (@(posedge clk) disable iff (reset)
		dest_write_en && ce |=> !dest_write_en)
		else $error("Destination write lasted more than one cycle.");
	freeze_hold_a: assert property (@(posedge clk) disable iff (reset)
		!ce |=> $stable(state_q) && $stable(dest_write_en) && $stable(verdict_valid))
		else $error("State moved while the clock enable was low.");
	range_gate_a: assert property (@(posedge clk) disable iff (reset)
		check_s and !in_range |=> dest_write_en)
		else $error("Unusable flag byte blocked a job.");
	copy_marked_a: assert property (@(posedge clk) disable iff (reset)
		ce && copy_wr |=> copy_fresh[$past(copy_addr)])
		else $error("Flag copy refresh not recorded.");
	area_code_a: assert property (@(posedge clk) disable iff (reset)
		check_s and locked |=> verdict.system_status_area == 8'h30
		&& receive_status_word[15:8] == 8'h09)
		else $error("Error codes 30H or 09H not reported.");

endmodule // cfg_guard

`default_nettype wire

// file: src/cfg_map.svh
// Constants of the coordination flag write guard: codes, counts and widths.
// Assumes nothing of its surroundings; included by the package, the guard, the flag copy and the bench.
`ifndef CFG_MAP_SVH
`define CFG_MAP_SVH

`define CFG_FLAG_BYTES 32
`define CFG_BYTE_AW 5
`define CFG_REPLY_LOCKED 8'h32
`define CFG_STATUS_LOCKED 8'h09
`define CFG_SYS_AREA_LOCKED 8'h30
`define CFG_JOB_STATUS_LOCKED 16'h0928
`define CFG_JOB_STATUS_OK 16'h0000
`define CFG_REPLY_OK 8'h00

`endif

// file: src/cfg_pkg.sv
// Types of the coordination flag write guard.
// Assumes the constant header cfg_map.svh is on the include path.
`include "cfg_map.svh"

package cfg_pkg;

	typedef struct packed {
		logic coord_used;
		logic [7:0] coord_byte;
		logic [2:0] coord_bit;
	} cfg_job_t;

	typedef struct packed {
		logic [7:0] reply_code;
		logic [15:0] job_status;
		logic [7:0] system_status_area;
	} cfg_verdict_t;

	typedef enum logic [1:0] {
		CFG_IDLE,
		CFG_CHECK,
		CFG_PASS,
		CFG_BLOCK
	} cfg_state_t;

endpackage

// file: src/cfg_flag_ram.sv
// Copy of the host's output communication flags, one byte per flag byte.
// Assumes one clock; the host side writes a byte, the guard reads with one cycle latency.
`timescale 1ns/100ps
`default_nettype none
`include "cfg_map.svh"

module cfg_flag_ram #(
	parameter int DEPTH = `CFG_FLAG_BYTES,
	parameter int AW = `CFG_BYTE_AW
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [7:0] rd_data
);

	logic [7:0] mem [DEPTH];

	if (DEPTH > (1 << AW))
	begin : g_bad_depth
		$error("Flag copy depth does not fit the address width.");
	end

	always_ff @(posedge clk)
	begin
		if (ce && wr_en)
			mem[wr_addr] <= wr_data;
	end

	// The read register keeps the guard's view stable for the decision cycle.
	always_ff @(posedge clk)
	begin
		// A refresh in the same cycle as the read is passed through, so it is never missed.
		if (ce)
		begin
			if (wr_en && wr_addr == rd_addr)
				rd_data <= wr_data;
			else
				rd_data <= mem[rd_addr];
		end
	end

endmodule // cfg_flag_ram

`default_nettype wire

// file: verif/cfg_host_model.sv
// Host side model: mirrors flag bytes into the guard's copy.
// Assumes the bench calls set_flags from a falling edge.
`timescale 1ns/100ps
`default_nettype none
module cfg_host_model (
	input wire logic clk,
	output logic copy_wr,
	output logic [4:0] copy_addr,
	output logic [7:0] copy_data,
	output logic cycle_end
);
	initial
	begin
		copy_wr = 1'b0;
		copy_addr = 5'h00;
		copy_data = 8'h00;
		cycle_end = 1'b0;
	end
	// Flags are plain bytes written by normal operations.
	// Only declared output bytes are sent, then the cycle end follows.
	task automatic set_flags(input logic [4:0] a, input logic [7:0] d);
		@(negedge clk);
		copy_wr = 1'b1;
		copy_addr = a;
		copy_data = d;
		@(negedge clk);
		copy_wr = 1'b0;
		copy_addr = ~a;
		copy_data = ~d;
		cycle_end = 1'b1;
		@(negedge clk);
		cycle_end = 1'b0;
	endtask
endmodule // cfg_host_model
`default_nettype wire

// file: verif/cfg_guard_tb_top.sv
// Self-checking bench of the coordination flag write guard.
// Assumes the guard, its package and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "cfg_map.svh"
module cfg_guard_tb_top;
	import cfg_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [31:0] en = '1;
	logic job_valid = 1'b0;
	cfg_job_t job_in = '0;
	logic copy_wr, cycle_end, job_ready, dest_write_en, verdict_valid;
	logic [4:0] copy_addr;
	logic [7:0] copy_data;
	cfg_verdict_t verdict;
	logic [15:0] receive_status_word;
	logic [31:0] copy_fresh;
	logic [7:0] flags [32];
	logic [31:0] seed = 32'hba25;
	int fail_count = 0;
	int tests_run = 0;
	always #20 clk = ~clk;
	cfg_host_model u_host (.clk(clk), .copy_wr(copy_wr), .copy_addr(copy_addr),
		.copy_data(copy_data), .cycle_end(cycle_end));
	cfg_guard u_dut (.clk(clk), .reset(reset), .ce(ce), .flag_enable_switch(en),
		.copy_wr(copy_wr), .copy_addr(copy_addr), .copy_data(copy_data),
		.cycle_end(cycle_end), .job_valid(job_valid), .job_in(job_in),
		.job_ready(job_ready), .dest_write_en(dest_write_en),
		.verdict_valid(verdict_valid), .verdict(verdict),
		.receive_status_word(receive_status_word), .copy_fresh(copy_fresh));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Bytes past 31 or disabled by switch never lock.
	function automatic logic locked(input cfg_job_t j);
		return j.coord_used && j.coord_byte < 8'h20 && en[j.coord_byte[4:0]]
			&& flags[j.coord_byte[4:0]][j.coord_bit];
	endfunction
	function automatic cfg_verdict_t exp_verdict(input logic lk);
		if (lk)
			return cfg_verdict_t'{`CFG_REPLY_LOCKED, `CFG_JOB_STATUS_LOCKED, `CFG_SYS_AREA_LOCKED};
		return cfg_verdict_t'{`CFG_REPLY_OK, `CFG_JOB_STATUS_OK, 8'h00};
	endfunction
	// The low byte carries the flag byte only for jobs that use a flag.
	function automatic logic [15:0] exp_status(input cfg_job_t j, input logic lk);
		return {lk ? `CFG_STATUS_LOCKED : 8'h00, j.coord_used ? j.coord_byte : 8'h00};
	endfunction
	task automatic note(input logic ok, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (!ok)
		begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		note(got === exp, 32'(got), 32'(exp));
	endtask
	task automatic chk_verdict(input cfg_verdict_t got, input cfg_verdict_t exp);
		note(got === exp, got, exp);
	endtask
	task automatic chk_status(input logic [15:0] got, input logic [15:0] exp);
		note(got === exp, 32'(got), 32'(exp));
	endtask
	task automatic chk_fresh(input logic [31:0] got, input logic [31:0] exp);
		note(got === exp, got, exp);
	endtask
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic set(input logic [4:0] a, input logic [7:0] d);
		flags[a] = d;
		u_host.set_flags(a, d);
	endtask
	task automatic run_job(input cfg_job_t j);
		logic lk;
		int n;
		lk = locked(j);
		job_in = j;
		job_valid = 1'b1;
		n = 0;
		while (job_ready !== 1'b1 && n < 8)
		begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		job_valid = 1'b0;
		while (verdict_valid !== 1'b1 && n < 13)
		begin
			@(negedge clk);
			n++;
		end
		if (verdict_valid !== 1'b1)
		begin
			fail_count++;
			complete_run();
		end
		chk_bit(dest_write_en, !lk);
		chk_verdict(verdict, exp_verdict(lk));
		chk_status(receive_status_word, exp_status(j, lk));
	endtask
	initial
	begin
		repeat (12) @(negedge clk);
		reset = 1'b0;
		chk_verdict(verdict, exp_verdict(1'b0));
		chk_bit(job_ready, 1'b1);
		// A low clock enable must leave an offered job untaken.
		ce = 1'b0;
		job_in = cfg_job_t'{1'b1, 8'h05, 3'h3};
		job_valid = 1'b1;
		repeat (3) @(negedge clk);
		chk_bit(verdict_valid, 1'b0);
		chk_bit(job_ready, 1'b1);
		job_valid = 1'b0;
		ce = 1'b1;
		for (int i = 0; i < 32; i++)
			set(i[4:0], 8'h00);
		chk_fresh(copy_fresh, 32'h0000_0000);
		set(5'h05, 8'h08);
		run_job(cfg_job_t'{1'b1, 8'h05, 3'h3});
		run_job(cfg_job_t'{1'b1, 8'h05, 3'h3});
		run_job(cfg_job_t'{1'b1, 8'h05, 3'h2});
		run_job(cfg_job_t'{1'b0, 8'h05, 3'h3});
		en[5] = 1'b0;
		run_job(cfg_job_t'{1'b1, 8'h05, 3'h3});
		en[5] = 1'b1;
		set(5'h05, 8'h00);
		run_job(cfg_job_t'{1'b1, 8'h05, 3'h3});
		set(5'h1f, 8'h80);
		run_job(cfg_job_t'{1'b1, 8'h1f, 3'h7});
		run_job(cfg_job_t'{1'b1, 8'h25, 3'h7});
		reset = 1'b1;
		@(negedge clk);
		reset = 1'b0;
		chk_verdict(verdict, exp_verdict(1'b0));
		chk_status(receive_status_word, 16'h0000);
		chk_bit(job_ready, 1'b1);
		repeat (80)
		begin
			seed = lfsr(seed);
			if (seed[0])
				set(seed[5:1], seed[13:6]);
			en = en ^ (32'h0000_0001 << seed[18:14]);
			run_job(cfg_job_t'{seed[19], 8'({2'b00, seed[25:20]} % 8'h28), seed[28:26]});
		end
		complete_run();
	end
endmodule // cfg_guard_tb_top
`default_nettype wire
